/* File: rtl/freq_prot_defs.vh */
/*
  Shared constants for the frequency protection stages: encodings,
  field widths and timing counts.
  Assumes a 100 MHz ref_clk and frequencies in units of 0.01 Hz (10 mHz).
*/
`ifndef FREQ_PROT_DEFS_VH
`define FREQ_PROT_DEFS_VH

// Clock and time base
`define CLK_FREQ_HZ       100000000
`define CYCLE_TIME_MS     5
`define CYCLE_COUNT       (`CLK_FREQ_HZ / 1000 * `CYCLE_TIME_MS)
`define STAMP_RES_MS      1
`define STAMP_COUNT       (`CLK_FREQ_HZ / 1000 * `STAMP_RES_MS)

// Frequency format: 16-bit, 10 mHz per LSB
`define FREQ_W            16
`define HYST_MHZ          20
`define FREQ_LSB_MHZ      10
`define HYST_CODE         16'h0002

// Stage enable encoding
`define ENABLE_NO         2'h1
`define ENABLE_YES        2'h2

// Forced status encoding
`define FORCE_NORMAL      2'h0
`define FORCE_START       2'h1
`define FORCE_TRIP        2'h2
`define FORCE_BLOCKED     2'h3

// Operating time in 5 ms steps, 0 means instant
`define OPTIME_W          19
`define GROUP_W           3
`define GROUPS            8
`define STAMP_W           32
`define COUNT_W           16

// Event record: stage index, signal, edge
`define EVT_SIG_START     2'h0
`define EVT_SIG_TRIP      2'h1
`define EVT_SIG_BLOCKED   2'h2

`endif

/* File: rtl/freq_stage.v */
/*
  One frequency stage: comparison with hysteresis, block check,
  definite-time delay, forcing and event edges, with counters.
  Assumes settings stable and cycle_tick one clock wide every 5 ms.
*/
`include "freq_prot_defs.vh"

module freq_stage #(
  parameter OVER   = 1,
  parameter FREQ_W = `FREQ_W,
  parameter TIME_W = `OPTIME_W,
  parameter CNT_W  = `COUNT_W
) (
  input  wire              ref_clk,
  input  wire              rst_n,
  input  wire              cycle_tick,
  input  wire [FREQ_W-1:0] freq,
  input  wire [FREQ_W-1:0] pickup,
  input  wire [TIME_W-1:0] op_time,
  input  wire [1:0]        enable,
  input  wire              block,
  input  wire              force_mode,
  input  wire [1:0]        force_status,
  input  wire              clear_counts,
  output reg               start,
  output reg               trip,
  output reg               blocked,
  output wire [2:0]        rise,
  output wire [2:0]        fall,
  output reg  [CNT_W-1:0]  start_count,
  output reg  [CNT_W-1:0]  trip_count,
  output reg  [CNT_W-1:0]  blocked_count
);

  reg  [TIME_W-1:0] timer;
  reg               picked;
  reg               prev_start;
  reg               prev_trip;
  reg               prev_blocked;
  reg               next_picked;
  reg               next_start;
  reg               next_trip;
  reg               next_blocked;
  wire              active;
  wire [FREQ_W:0]   up_rel;
  wire [FREQ_W:0]   dn_rel;

  assign active = (enable == `ENABLE_YES);
  assign up_rel = {1'b0, pickup} - {1'b0, `HYST_CODE};
  assign dn_rel = {1'b0, pickup} + {1'b0, `HYST_CODE};

  ////////////////////////////////////////////////////////////////////////
  // Comparison, block, delay and output in one pass
  always @* begin
    next_picked  = picked;
    next_start   = 1'b0;
    next_trip    = 1'b0;
    next_blocked = 1'b0;
    if (OVER != 0) begin
      if (!picked)
        next_picked = (freq > pickup);
      else
        next_picked = ({1'b0, freq} > up_rel);
    end else begin
      if (!picked)
        next_picked = (freq < pickup);
      else
        next_picked = ({1'b0, freq} < dn_rel);
    end
    if (!active)
      next_picked = 1'b0;
    if (next_picked && block) begin
      next_blocked = 1'b1;
    end else if (next_picked) begin
      next_start = 1'b1;
      if (op_time == {TIME_W{1'b0}})
        next_trip = 1'b1;
      else if (timer + 1'b1 >= op_time)
        next_trip = 1'b1;
    end
    if (force_mode && active) begin
      case (force_status)
        `FORCE_START: begin
          next_start = 1'b1;
          next_trip = 1'b0;
          next_blocked = 1'b0;
        end
        `FORCE_TRIP: begin
          next_start = 1'b1;
          next_trip = 1'b1;
          next_blocked = 1'b0;
        end
        `FORCE_BLOCKED: begin
          next_start = 1'b0;
          next_trip = 1'b0;
          next_blocked = 1'b1;
        end
        default: begin
          next_start = next_start;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State update once per processing cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      picked  <= 1'b0;
      start   <= 1'b0;
      trip    <= 1'b0;
      blocked <= 1'b0;
      timer   <= {TIME_W{1'b0}};
    end else if (cycle_tick) begin
      picked  <= next_picked;
      start   <= next_start;
      trip    <= next_trip;
      blocked <= next_blocked;
      if (next_picked && !block && !trip && timer != {TIME_W{1'b1}})
        timer <= timer + 1'b1;
      else if (!next_picked || block)
        timer <= {TIME_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edges and cumulative counters
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_start    <= 1'b0;
      prev_trip     <= 1'b0;
      prev_blocked  <= 1'b0;
      start_count   <= {CNT_W{1'b0}};
      trip_count    <= {CNT_W{1'b0}};
      blocked_count <= {CNT_W{1'b0}};
    end else begin
      prev_start   <= start;
      prev_trip    <= trip;
      prev_blocked <= blocked;
      if (rise[0])
        start_count <= start_count + 1'b1;
      else if (clear_counts)
        start_count <= {CNT_W{1'b0}};
      if (rise[1])
        trip_count <= trip_count + 1'b1;
      else if (clear_counts)
        trip_count <= {CNT_W{1'b0}};
      if (rise[2])
        blocked_count <= blocked_count + 1'b1;
      else if (clear_counts)
        blocked_count <= {CNT_W{1'b0}};
    end
  end

  assign rise = {blocked & ~prev_blocked, trip & ~prev_trip, start & ~prev_start};
  assign fall = {~blocked & prev_blocked, ~trip & prev_trip, ~start & prev_start};

endmodule

/* File: rtl/freq_protection.v */
/*
  Four overfrequency and four underfrequency stages with setting groups,
  processing-cycle timing, millisecond time stamps and an event port.
  Assumes frequency words from the measurement front end (10 mHz units)
  and block inputs from the blocking matrix, all asynchronous to ref_clk.
*/
// Functional notes
// - Four overfrequency and four underfrequency stages, each with own outputs.
// - Per-stage enable, 1 disabled 2 enabled; disabled stage stays silent.
// - Eight setting groups; one common selector applies to all stages.
// - Each stage supports instant and time-delayed operation.
// - Each cycle: input, compare, block check, delay, output, in order.
// - Over stages pick up above setting, under stages below it.
// - Each stage drives start, trip and blocked outputs.
// - Every edge of each output of stages 0-5 posts a time-stamped ON or OFF event; stages 6 and 7 post none.
// - Instant mode emits start and trip events with the same stamp.
// - Event time stamps have one millisecond resolution.
// - Cumulative start, trip, blocked counters, clearable on request.
// - Frequency from first or second transformer, refreshed every 5 ms.
// - Frequency source follows the tracking reference setting.
// - Enables and forcing are static, unaffected by group changes.
// - Forced status 0-3 acts only while stage forcing is enabled.
// - Fixed 20 mHz hysteresis relative to pick-up before release.
// - Block input sampled at the start of each processing cycle.
// - Block at pick-up gives blocked, not start; active start resets.
// - Delayed mode is definite time with a per-stage operating time.
`include "freq_prot_defs.vh"

module freq_protection #(
  parameter FREQ_W     = `FREQ_W,
  parameter TIME_W     = `OPTIME_W,
  parameter CNT_W      = `COUNT_W,
  parameter STAMP_W    = `STAMP_W,
  parameter CYCLE_CLKS = `CYCLE_COUNT,
  parameter STAMP_CLKS = `STAMP_COUNT
) (
  input  wire                          ref_clk,
  input  wire                          rst_n,
  input  wire [FREQ_W-1:0]             freq_first_voltage_transformer,
  input  wire [FREQ_W-1:0]             freq_second_voltage_transformer,
  input  wire                          tracking_reference,
  input  wire [`GROUP_W-1:0]           setting_group,
  input  wire [`GROUPS*8*FREQ_W-1:0]   pickup_table,
  input  wire [`GROUPS*8*TIME_W-1:0]   op_time_table,
  input  wire [15:0]                   stage_enable,
  input  wire                          force_mode,
  input  wire [15:0]                   force_status,
  input  wire [7:0]                    block_in,
  input  wire                          clear_counts,
  output wire [7:0]                    start,
  output wire [7:0]                    trip,
  output wire [7:0]                    blocked,
  output reg                           event_valid,
  output reg  [2:0]                    event_stage,
  output reg  [1:0]                    event_signal,
  output reg                           event_on,
  output reg  [STAMP_W-1:0]            event_stamp,
  output wire [8*3*CNT_W-1:0]          counters,
  output reg  [STAMP_W-1:0]            time_ms
);

  reg  [FREQ_W-1:0]   freq_a1;
  reg  [FREQ_W-1:0]   freq_a2;
  reg  [FREQ_W-1:0]   freq_b1;
  reg  [FREQ_W-1:0]   freq_b2;
  reg  [FREQ_W-1:0]   freq_a3;
  reg  [FREQ_W-1:0]   freq_b3;
  wire                emit;
  wire [47:0]         clr_rise;
  wire [47:0]         clr_fall;
  reg  [7:0]          block_s1;
  reg  [7:0]          block_s2;
  reg  [7:0]          block_cyc;
  reg  [FREQ_W-1:0]   freq_cyc;
  reg  [31:0]         cycle_cnt;
  reg  [31:0]         ms_cnt;
  reg                 cycle_tick;
  reg  [47:0]         pend_rise;
  reg  [47:0]         pend_fall;
  reg  [STAMP_W-1:0]  pend_stamp [0:7];
  reg  [5:0]          scan;
  wire [23:0]         rise_all;
  wire [23:0]         fall_all;
  wire [2:0]          scan_stage;
  wire [1:0]          scan_sig;
  wire [5:0]          scan_idx;
  integer             k;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_a1  <= {FREQ_W{1'b0}};
      freq_a2  <= {FREQ_W{1'b0}};
      freq_b1  <= {FREQ_W{1'b0}};
      freq_b2  <= {FREQ_W{1'b0}};
      freq_a3  <= {FREQ_W{1'b0}};
      freq_b3  <= {FREQ_W{1'b0}};
      block_s1 <= 8'h00;
      block_s2 <= 8'h00;
    end else begin
      freq_a1  <= freq_first_voltage_transformer;
      freq_a2  <= freq_a1;
      freq_b1  <= freq_second_voltage_transformer;
      freq_b2  <= freq_b1;
      freq_a3  <= freq_a2;
      freq_b3  <= freq_b2;
      block_s1 <= block_in;
      block_s2 <= block_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Processing cycle and millisecond stamp
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_cnt  <= 32'h00000000;
      ms_cnt     <= 32'h00000000;
      cycle_tick <= 1'b0;
      time_ms    <= {STAMP_W{1'b0}};
      freq_cyc   <= {FREQ_W{1'b0}};
      block_cyc  <= 8'h00;
    end else begin
      cycle_tick <= 1'b0;
      if (cycle_cnt == CYCLE_CLKS - 1) begin
        cycle_cnt  <= 32'h00000000;
        cycle_tick <= 1'b1;
        // Word taken only when steady for two clocks
        if (tracking_reference ? (freq_b2 == freq_b3) : (freq_a2 == freq_a3))
          freq_cyc <= tracking_reference ? freq_b2 : freq_a2;
        block_cyc  <= block_s2;
      end else begin
        cycle_cnt <= cycle_cnt + 32'h00000001;
      end
      if (ms_cnt == STAMP_CLKS - 1) begin
        ms_cnt  <= 32'h00000000;
        time_ms <= time_ms + 1'b1;
      end else begin
        ms_cnt <= ms_cnt + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stages
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : stage
      freq_stage #(
        .OVER   ((g < 4) ? 1 : 0),
        .FREQ_W (FREQ_W),
        .TIME_W (TIME_W),
        .CNT_W  (CNT_W)
      ) u_stage (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .cycle_tick    (cycle_tick),
        .freq          (freq_cyc),
        .pickup        (pickup_table[(setting_group*8+g)*FREQ_W +: FREQ_W]),
        .op_time       (op_time_table[(setting_group*8+g)*TIME_W +: TIME_W]),
        .enable        (stage_enable[2*g +: 2]),
        .block         (block_cyc[g]),
        .force_mode    (force_mode),
        .force_status  (force_status[2*g +: 2]),
        .clear_counts  (clear_counts),
        .start         (start[g]),
        .trip          (trip[g]),
        .blocked       (blocked[g]),
        .rise          (rise_all[3*g +: 3]),
        .fall          (fall_all[3*g +: 3]),
        .start_count   (counters[(3*g)*CNT_W +: CNT_W]),
        .trip_count    (counters[(3*g+1)*CNT_W +: CNT_W]),
        .blocked_count (counters[(3*g+2)*CNT_W +: CNT_W])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Event posting: edges latched with their stamp, then sent one a clock
  assign scan_stage = scan[5:3];
  assign scan_sig   = scan[1:0];
  assign scan_idx   = scan;
  assign emit       = (scan_sig != 2'h3) && (pend_rise[scan_idx] || pend_fall[scan_idx]);
  assign clr_rise   = (emit && pend_rise[scan_idx]) ?
                      (48'h000000000001 << scan_idx) : 48'h000000000000;
  assign clr_fall   = (emit && !pend_rise[scan_idx]) ?
                      (48'h000000000001 << scan_idx) : 48'h000000000000;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_rise    <= 48'h000000000000;
      pend_fall    <= 48'h000000000000;
      scan         <= 6'h00;
      event_valid  <= 1'b0;
      event_stage  <= 3'h0;
      event_signal <= 2'h0;
      event_on     <= 1'b0;
      event_stamp  <= {STAMP_W{1'b0}};
      for (k = 0; k < 8; k = k + 1)
        pend_stamp[k] <= {STAMP_W{1'b0}};
    end else begin
      event_valid <= 1'b0;
      if (emit) begin
        event_valid  <= 1'b1;
        event_stage  <= scan_stage;
        event_signal <= scan_sig;
        event_on     <= pend_rise[scan_idx];
        event_stamp  <= pend_stamp[scan_stage];
        if (pend_rise[scan_idx])
          pend_rise[scan_idx] <= 1'b0;
        else
          pend_fall[scan_idx] <= 1'b0;
      end
      scan <= scan + 6'h01;
      for (k = 0; k < 8; k = k + 1) begin
        if (|rise_all[3*k +: 3] || |fall_all[3*k +: 3]) begin
          pend_stamp[k] <= time_ms;
          // Sent bit dropped here too, new edges still kept
          pend_rise[8*k +: 3] <= (pend_rise[8*k +: 3] & ~clr_rise[8*k +: 3]) | rise_all[3*k +: 3];
          pend_fall[8*k +: 3] <= (pend_fall[8*k +: 3] & ~clr_fall[8*k +: 3]) | fall_all[3*k +: 3];
        end
      end
    end
  end

endmodule

/* File: testbench/freq_front_end.sv */
/*
  Behavioural front end: measured frequency words and block levels.
  Assumes the bench sets targets; values refresh on the processing time base.
*/
module freq_front_end #(
  parameter int REFRESH = 50
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] f1_set,
  input  wire logic [15:0] f2_set,
  input  wire logic [7:0]  blk_set,
  output logic      [15:0] freq1,
  output logic      [15:0] freq2,
  output logic      [7:0]  block_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Refresh every time base, block arrives ahead of the next cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      freq1 <= 16'h1388;
      freq2 <= 16'h1388;
      block_out <= 8'h00;
    end else if (cnt == REFRESH - 1) begin
      cnt <= 0;
      freq1 <= f1_set;
      freq2 <= f2_set;
      block_out <= blk_set;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

/* File: testbench/freq_protection_properties.sv */
/*
  Checker for the frequency stages, bound to the top module.
  Assumes processing cycles longer than eight clocks.
*/
`include "freq_prot_defs.vh"
module freq_prot_properties #(
  parameter TIME_W     = `OPTIME_W,
  parameter CNT_W      = `COUNT_W,
  parameter STAMP_W    = `STAMP_W,
  parameter STAMP_CLKS = `STAMP_COUNT
) (
  input wire                        ref_clk,
  input wire                        rst_n,
  input wire [`GROUP_W-1:0]         setting_group,
  input wire [`GROUPS*8*TIME_W-1:0] op_time_table,
  input wire [15:0]                 stage_enable,
  input wire                        force_mode,
  input wire                        clear_counts,
  input wire [7:0]                  start,
  input wire [7:0]                  trip,
  input wire [7:0]                  blocked,
  input wire                        event_valid,
  input wire [2:0]                  event_stage,
  input wire [1:0]                  event_signal,
  input wire                        event_on,
  input wire [STAMP_W-1:0]          event_stamp,
  input wire [8*3*CNT_W-1:0]        counters,
  input wire [STAMP_W-1:0]          time_ms
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAG = 64 / STAMP_CLKS + 1;
  logic [7:0]        dis;
  logic [7:0]        since_force;
  wire               quiet = since_force == 8'hc8;
  wire  [TIME_W-1:0] op0 = op_time_table[setting_group*8*TIME_W +: TIME_W];
  always @* begin
    for (int i = 0; i < 8; i++) dis[i] = stage_enable[2*i +: 2] != 2'h2;
  end
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) since_force <= 8'h00;
    else if (force_mode) since_force <= 8'h00;
    else if (!quiet) since_force <= since_force + 8'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_disabled_quiet: assert property ($stable(dis) |-> ((start | trip | blocked) & dis) == 8'h00)
    else $error("disabled stage drives an output");
  a_block_excl: assert property (quiet |-> (blocked & (start | trip)) == 8'h00)
    else $error("blocked together with start or trip");
  a_trip_with_start: assert property (quiet |-> (trip & ~start) == 8'h00)
    else $error("trip without start");
  a_output_spacing: assert property ($changed({start, trip, blocked}) |=>
    $stable({start, trip, blocked})[*8])
    else $error("outputs changed twice within a cycle");
  a_event_fields: assert property (!event_valid |->
    $stable({event_stage, event_signal, event_on, event_stamp}))
    else $error("event fields moved without a pulse");
  a_stamp_recent: assert property (event_valid |->
    event_stamp <= time_ms && time_ms - event_stamp <= LAG)
    else $error("event stamp out of range");
  a_start_event: assert property ($rose(start[0]) |-> ##[1:70] (event_valid &&
    event_stage == 3'h0 && event_signal == 2'h0 && event_on))
    else $error("start on event missing");
  a_trip_off_event: assert property ($fell(trip[0]) |-> ##[1:70] (event_valid &&
    event_stage == 3'h0 && event_signal == 2'h1 && !event_on))
    else $error("trip off event missing");
  a_blocked_event: assert property ($rose(blocked[5]) |-> ##[1:70] (event_valid &&
    event_stage == 3'h5 && event_signal == 2'h2 && event_on))
    else $error("blocked on event missing");
  a_instant_pair: assert property ($rose(start[0]) && op0 == '0 && quiet |-> trip[0])
    else $error("instant start without trip");
  a_time_step: assert property ($changed(time_ms) |-> time_ms == $past(time_ms) + 1)
    else $error("millisecond counter skipped");
  a_clear_counts: assert property (clear_counts [*5] |-> counters == '0)
    else $error("counters not cleared");
endmodule

/* File: testbench/test_freq_protection.sv */
/*
  Self-checking bench for the frequency stages.
  Assumes short cycle and stamp counts set through the top parameters.
*/
`include "freq_prot_defs.vh"
module test_freq_protection;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 80;
  localparam int STP = 10;
  reg                        ref_clk, rst_n, trk, force_mode, clear_counts, prev;
  reg  [2:0]                 setting_group, v;
  reg  [`GROUPS*8*16-1:0]    pickup_table;
  reg  [`GROUPS*8*19-1:0]    op_time_table;
  reg  [15:0]                stage_enable, force_status, f1, f2, fv;
  reg  [7:0]                 blk;
  reg  [31:0]                t0;
  reg  [31:0]                stamp_seen [0:1];
  wire [15:0]                freq1, freq2;
  wire [7:0]                 block_in, start, trip, blocked;
  wire                       event_valid, event_on;
  wire [2:0]                 event_stage;
  wire [1:0]                 event_signal;
  wire [31:0]                event_stamp, time_ms;
  wire [383:0]               counters;
  int                        bad_count, n_tests, seed, grp;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  freq_front_end #(.REFRESH(CYC)) u_front (.ref_clk(ref_clk), .rst_n(rst_n), .f1_set(f1),
    .f2_set(f2), .blk_set(blk), .freq1(freq1), .freq2(freq2), .block_out(block_in));
  freq_protection #(.CYCLE_CLKS(CYC), .STAMP_CLKS(STP)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .freq_first_voltage_transformer(freq1), .freq_second_voltage_transformer(freq2),
    .tracking_reference(trk), .setting_group(setting_group), .pickup_table(pickup_table),
    .op_time_table(op_time_table), .stage_enable(stage_enable), .force_mode(force_mode),
    .force_status(force_status), .block_in(block_in), .clear_counts(clear_counts),
    .start(start), .trip(trip), .blocked(blocked), .event_valid(event_valid),
    .event_stage(event_stage), .event_signal(event_signal), .event_on(event_on),
    .event_stamp(event_stamp), .counters(counters), .time_ms(time_ms));
  ////////////////////////////////////////////////////////////////////////////
  // Stamps of stage 0 start and trip ON events
  always @(posedge ref_clk) begin
    if (event_valid === 1'b1 && event_stage === 3'h0 && event_on === 1'b1 && event_signal < 2'h2)
      stamp_seen[event_signal[0]] <= event_stamp;
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask
  task tk(input int n);
    repeat (n * CYC) @(posedge ref_clk);
  endtask
  function logic over_pick(input logic was, input int f, input int p);
    return was ? (f > p - 2) : (f > p);
  endfunction
  task finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 26765;
    rst_n = 1'b0;
    {trk, force_mode, clear_counts, force_status, blk} = '0;
    f1 = 16'h1388;
    f2 = 16'h1388;
    stage_enable = 16'haa6a;
    stamp_seen[0] = 32'h0;
    stamp_seen[1] = 32'hffffffff;
    grp = {$random(seed)} % 8;
    setting_group = 3'(grp);
    for (int g = 0; g < 8; g++) begin
      for (int s = 0; s < 8; s++) begin
        pickup_table[(g*8+s)*16 +: 16] = 16'((s < 4 ? 16'h1450 : 16'h10cc) +
          {$random(seed)} % 16'h01f4);
        op_time_table[(g*8+s)*19 +: 19] = 19'({$random(seed)} % 8);
        if (g == grp) begin
          pickup_table[(g*8+s)*16 +: 16] = s < 4 ? 16'h13ec : 16'h1324;
          op_time_table[(g*8+s)*19 +: 19] = s % 4 == 0 ? 19'h0 : s % 4 == 1 ? 19'h3 : 19'h2;
        end
      end
    end
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    tk(3);
    check("idle outputs", {start, trip, blocked}, 0);
    @(posedge ref_clk) f1 <= 16'h13ed;
    for (int i = 0; i < 5 * CYC && start[0] !== 1'b1; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    check("instant trip", trip[0], 1'b1);
    tk(1);
    check("delayed trip early", trip[1], 1'b0);
    tk(4);
    check("over outputs", {start, trip, blocked}, 24'h070700);
    f1 <= 16'h13eb;
    tk(4);
    check("hysteresis hold", start[0], 1'b1);
    f1 <= 16'h13ea;
    tk(4);
    check("hysteresis release", {start[0], trip[0]}, 2'b00);
    check("pair stamps", stamp_seen[0], stamp_seen[1]);
    check("start count", counters[15:0], 16'h0001);
    check("trip count", counters[31:16], 16'h0001);
    t0 = time_ms;
    repeat (10 * STP) @(posedge ref_clk);
    check("ms tick", time_ms - t0, 32'h0000000a);
    f2 <= 16'h1323;
    trk <= 1'b1;
    tk(4);
    check("under start", {start, trip[4]}, 9'h1e1);
    blk <= 8'h20;
    tk(4);
    check("block", {start, blocked}, 16'hd020);
    check("blocked count", counters[17*16 +: 16], 16'h0001);
    setting_group <= 3'(grp + 1);
    blk <= 8'h00;
    tk(4);
    check("group switch", {start, trip, blocked}, 0);
    force_mode <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      force_status <= {2'h0, 2'(c), 4'h0, 2'h1, 6'h00};
      tk(3);
      v = {blocked[6], trip[6], start[6]};
      check("forced status", c == 0 ? {29'h0, v} : {31'h0, v[c-1]}, c != 0);
      check("forced disabled", start[3], 1'b0);
    end
    force_mode <= 1'b0;
    force_status <= 16'h2000;
    tk(3);
    check("force ignored", trip[6], 1'b0);
    clear_counts <= 1'b1;
    tk(1);
    check("counters cleared", |counters, 1'b0);
    clear_counts <= 1'b0;
    setting_group <= 3'(grp);
    trk <= 1'b0;
    prev = 1'b0;
    repeat (8) begin
      fv = 16'(16'h13e7 + {$random(seed)} % 12);
      f1 <= fv;
      tk(4);
      prev = over_pick(prev, fv, 16'h13ec);
      check("random pick", start[0], prev);
    end
    finish_test;
  end
endmodule
bind freq_protection freq_prot_properties #(.TIME_W(TIME_W), .CNT_W(CNT_W), .STAMP_W(STAMP_W),
  .STAMP_CLKS(STAMP_CLKS)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .setting_group(setting_group), .op_time_table(op_time_table), .stage_enable(stage_enable),
  .force_mode(force_mode), .clear_counts(clear_counts), .start(start), .trip(trip),
  .blocked(blocked), .event_valid(event_valid), .event_stage(event_stage),
  .event_signal(event_signal), .event_on(event_on), .event_stamp(event_stamp),
  .counters(counters), .time_ms(time_ms));
